// File: rtl/timer16_capture.v
// Purpose: 16-bit up/down timer with input capture and shared high-byte holding register
// Assumes: all inputs synchronous to clk; one bus access per cycle
// Notes:   compare outputs, noise filter and compare double buffering are not built

`include "timer16_regs.vh"

module timer16_capture #(
  parameter PRESCALE_W = 10
) (
  input  wire       clk,
  input  wire       rst,
  input  wire [3:0] addr,
  input  wire       wr,
  input  wire       rd,
  input  wire [7:0] wdata,
  output reg  [7:0] rdata_ff,
  input  wire       ext_clk_pin,
  input  wire       capture_pin,
  input  wire       comparator_output,
  input  wire       capture_src_sel,
  input  wire       capture_irq_ack,
  input  wire       overflow_irq_ack,
  output reg        capture_irq_ff,
  output reg        overflow_irq_ff,
  output reg        top_hit_ff,
  output reg        bottom_hit_ff
);

  reg  [7:0]            control_reg_a_ff;
  reg  [7:0]            control_reg_b_ff;
  reg  [15:0]           timer_count_value_ff;
  reg  [15:0]           capture_value_reg_ff;
  reg  [15:0]           compare_a_ff;
  reg  [15:0]           compare_b_ff;
  reg  [7:0]            hold_ff;
  reg                   overflow_flag_ff;
  reg                   capture_flag_ff;
  reg                   overflow_irq_en_ff;
  reg                   capture_irq_enable_ff;
  reg                   down_ff;
  reg                   ext_prev_ff;
  reg                   cap_prev_ff;
  reg  [PRESCALE_W-1:0] pre_ff;

  reg  [15:0]           nxt_count;
  reg                   nxt_down;
  reg                   nxt_ovf;
  reg                   timer_tick;
  reg  [7:0]            rd_val;
  reg  [7:0]            nxt_hold;
  reg  [15:0]           nxt_capture;
  reg                   nxt_cap_flag;
  reg                   nxt_ovf_flag;
  wire [3:0]            tap_zero;

  wire [3:0]  waveform_mode_field = {control_reg_b_ff[4:3], control_reg_a_ff[1:0]};
  wire [2:0]  clock_source_field  = control_reg_b_ff[2:0];
  wire        edge_rising         = control_reg_b_ff[`BIT_EDGE];
  wire        wr_cnt_lo           = wr && (addr == `OFS_CNT_LO);
  wire        rd_cnt_lo           = rd && (addr == `OFS_CNT_LO);
  wire        rd_cap_lo           = rd && (addr == `OFS_CAP_LO);
  wire        cap_top_mode        = top_from_capture(waveform_mode_field);
  wire [15:0] top_val             = top_of(waveform_mode_field, compare_a_ff,
                                           capture_value_reg_ff);
  wire        dual_slope          = is_dual(waveform_mode_field);
  wire        cap_level           = capture_src_sel ? comparator_output : capture_pin;
  wire        cap_edge            = (cap_level != cap_prev_ff) && (cap_level == edge_rising);
  // capture input is off while the capture register defines top
  wire        capture_trig        = cap_edge && !cap_top_mode;
  wire        ext_fall            = ext_prev_ff && !ext_clk_pin;
  wire        ext_rise            = !ext_prev_ff && ext_clk_pin;

  // modes where the capture register defines top
  function top_from_capture;
    input [3:0] m;
    begin
      top_from_capture = (m == 4'd8) || (m == 4'd10) || (m == 4'd12) || (m == 4'd14);
    end
  endfunction

  function is_dual;
    input [3:0] m;
    begin
      is_dual = (m >= 4'd1 && m <= 4'd3) || (m >= 4'd8 && m <= 4'd11);
    end
  endfunction

  // register tops are passed in so the continuous assignment sees their changes
  function [15:0] top_of;
    input [3:0]  m;
    input [15:0] cmp_top;
    input [15:0] cap_top;
    begin
      case (m)
        4'd1, 4'd5:                 top_of = `TOP_8BIT;
        4'd2, 4'd6:                 top_of = `TOP_9BIT;
        4'd3, 4'd7:                 top_of = `TOP_10BIT;
        4'd4, 4'd9, 4'd11, 4'd15:   top_of = cmp_top;
        4'd8, 4'd10, 4'd12, 4'd14:  top_of = cap_top;
        default:                    top_of = `TOP_MAX;
      endcase
    end
  endfunction

  // high-byte locations of all four 16-bit registers
  function is_hi_addr;
    input [3:0] a;
    begin
      is_hi_addr = (a == `OFS_CNT_HI) || (a == `OFS_CAP_HI) ||
                   (a == `OFS_CMPA_HI) || (a == `OFS_CMPB_HI);
    end
  endfunction

  // write-one-clear decode shared by both flags
  function w1c;
    input       w;
    input [3:0] a;
    input       d;
    begin
      w1c = w && (a == `OFS_FLAGS) && d;
    end
  endfunction

  // zero detect per prescaler tap: /8, /64, /256 and the full divider
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_tap
      localparam integer TW = (g == 0) ? `TAP0_W : (g == 1) ? `TAP1_W :
                              (g == 2) ? `TAP2_W : PRESCALE_W;
      assign tap_zero[g] = (pre_ff[TW-1:0] == {TW{1'b0}});
    end
  endgenerate

  // tick select; prescaler taps are a plain divider, no shared prescaler reset
  always @* begin
    case (clock_source_field)
      3'd1:    timer_tick = 1'b1;
      3'd2:    timer_tick = tap_zero[0];
      3'd3:    timer_tick = tap_zero[1];
      3'd4:    timer_tick = tap_zero[2];
      3'd5:    timer_tick = tap_zero[3];
      3'd6:    timer_tick = ext_fall;
      3'd7:    timer_tick = ext_rise;
      default: timer_tick = 1'b0;
    endcase
  end

  // counting sequence per tick
  always @* begin
    nxt_count = timer_count_value_ff;
    nxt_down  = down_ff;
    nxt_ovf   = 1'b0;
    if (timer_tick) begin
      if (!dual_slope) begin
        if (timer_count_value_ff == top_val) begin
          nxt_count = 16'h0000;
          nxt_ovf   = 1'b1;
        end else begin
          nxt_count = timer_count_value_ff + 16'h0001;
        end
        nxt_down = 1'b0;
      end else if (!down_ff) begin
        if (timer_count_value_ff >= top_val) begin
          nxt_count = timer_count_value_ff - 16'h0001;
          nxt_down  = 1'b1;
        end else begin
          nxt_count = timer_count_value_ff + 16'h0001;
        end
      end else begin
        if (timer_count_value_ff == 16'h0000) begin
          nxt_count = 16'h0001;
          nxt_down  = 1'b0;
          nxt_ovf   = 1'b1;
        end else begin
          nxt_count = timer_count_value_ff - 16'h0001;
        end
      end
    end
    if (wr_cnt_lo) begin
      nxt_count = {hold_ff, wdata};
    end
  end

  // read mux; high-byte locations of count and capture read the holding byte
  always @* begin
    case (addr)
      `OFS_CTRL_A:  rd_val = control_reg_a_ff;
      `OFS_CTRL_B:  rd_val = control_reg_b_ff;
      `OFS_CNT_LO:  rd_val = timer_count_value_ff[7:0];
      `OFS_CNT_HI:  rd_val = hold_ff;
      `OFS_CAP_LO:  rd_val = capture_value_reg_ff[7:0];
      `OFS_CAP_HI:  rd_val = hold_ff;
      `OFS_CMPA_LO: rd_val = compare_a_ff[7:0];
      `OFS_CMPA_HI: rd_val = compare_a_ff[15:8];
      `OFS_CMPB_LO: rd_val = compare_b_ff[7:0];
      `OFS_CMPB_HI: rd_val = compare_b_ff[15:8];
      `OFS_FLAGS:   rd_val = {2'b00, capture_flag_ff, 4'h0, overflow_flag_ff};
      `OFS_MASK:    rd_val = {2'b00, capture_irq_enable_ff, 4'h0, overflow_irq_en_ff};
      default:      rd_val = 8'h00;
    endcase
  end

  // prescaler and pin history
  always @(posedge clk) begin
    if (rst) begin
      pre_ff      <= {PRESCALE_W{1'b0}};
      ext_prev_ff <= 1'b0;
      cap_prev_ff <= 1'b0;
    end else begin
      pre_ff      <= pre_ff + {{(PRESCALE_W-1){1'b0}}, 1'b1};
      ext_prev_ff <= ext_clk_pin;
      cap_prev_ff <= cap_level;
    end
  end

  // counter and slope direction
  always @(posedge clk) begin
    if (rst) begin
      timer_count_value_ff <= 16'h0000;
      down_ff              <= 1'b0;
    end else begin
      timer_count_value_ff <= nxt_count;
      // a count write keeps the slope so the next tick goes on the same way
      down_ff              <= wr_cnt_lo ? down_ff : nxt_down;
    end
  end

  // read data stands one cycle, zero when idle
  always @(posedge clk) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= rd ? rd_val : 8'h00;
    end
  end

  // one holding byte for every 16-bit register
  always @* begin
    nxt_hold = hold_ff;
    if (wr && is_hi_addr(addr)) begin
      nxt_hold = wdata;
    end else if (rd_cnt_lo) begin
      nxt_hold = timer_count_value_ff[15:8];
    end else if (rd_cap_lo) begin
      nxt_hold = capture_value_reg_ff[15:8];
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      hold_ff <= 8'h00;
    end else begin
      hold_ff <= nxt_hold;
    end
  end

  // plain 8-bit registers and compare pairs; compare tops take effect at once
  always @(posedge clk) begin
    if (rst) begin
      control_reg_a_ff      <= `CTRL_RESET;
      control_reg_b_ff      <= `CTRL_RESET;
      compare_a_ff          <= 16'h0000;
      compare_b_ff          <= 16'h0000;
      overflow_irq_en_ff    <= 1'b0;
      capture_irq_enable_ff <= 1'b0;
    end else if (wr) begin
      case (addr)
        `OFS_CTRL_A:  control_reg_a_ff      <= wdata;
        `OFS_CTRL_B:  control_reg_b_ff      <= wdata;
        `OFS_CMPA_LO: compare_a_ff          <= {hold_ff, wdata};
        `OFS_CMPB_LO: compare_b_ff          <= {hold_ff, wdata};
        `OFS_MASK: begin
          capture_irq_enable_ff <= wdata[`BIT_CAPF];
          overflow_irq_en_ff    <= wdata[`BIT_OVF];
        end
        default: ;
      endcase
    end
  end

  // capture copy wins over a processor write in the same cycle
  always @* begin
    nxt_capture = capture_value_reg_ff;
    if (capture_trig) begin
      nxt_capture = timer_count_value_ff;
    end else if (wr && (addr == `OFS_CAP_LO) && cap_top_mode) begin
      nxt_capture = {hold_ff, wdata};
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      capture_value_reg_ff <= 16'h0000;
    end else begin
      capture_value_reg_ff <= nxt_capture;
    end
  end

  // set wins over write-one-clear and over interrupt service
  always @* begin
    nxt_cap_flag = capture_flag_ff;
    nxt_ovf_flag = overflow_flag_ff;
    if (capture_trig) begin
      nxt_cap_flag = 1'b1;
    end else if (capture_irq_ack) begin
      nxt_cap_flag = 1'b0;
    end else if (w1c(wr, addr, wdata[`BIT_CAPF])) begin
      nxt_cap_flag = 1'b0;
    end
    // a count write in the wrap cycle swallows that overflow
    if (nxt_ovf && !wr_cnt_lo) begin
      nxt_ovf_flag = 1'b1;
    end else if (overflow_irq_ack) begin
      nxt_ovf_flag = 1'b0;
    end else if (w1c(wr, addr, wdata[`BIT_OVF])) begin
      nxt_ovf_flag = 1'b0;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      capture_flag_ff  <= 1'b0;
      overflow_flag_ff <= 1'b0;
    end else begin
      capture_flag_ff  <= nxt_cap_flag;
      overflow_flag_ff <= nxt_ovf_flag;
    end
  end

  // status outputs follow the count on the same edge; irqs drop at once on service
  always @(posedge clk) begin
    if (rst) begin
      capture_irq_ff  <= 1'b0;
      overflow_irq_ff <= 1'b0;
      top_hit_ff      <= 1'b0;
      bottom_hit_ff   <= 1'b0;
    end else begin
      capture_irq_ff  <= capture_flag_ff && capture_irq_enable_ff && !capture_irq_ack;
      overflow_irq_ff <= overflow_flag_ff && overflow_irq_en_ff && !overflow_irq_ack;
      top_hit_ff      <= (nxt_count == top_val);
      bottom_hit_ff   <= (nxt_count == 16'h0000);
    end
  end

endmodule // timer16_capture

// File: include/timer16_regs.vh
// Purpose: constants for the 16-bit timer with input capture
// Assumes: 8-bit internal data bus, byte offsets below
// Notes:   offsets and bit positions are local choices
// Summary of operation
// - one written high-byte value serves every later low-byte write until rewritten or reloaded by a count or capture low-byte read
// - clock-source field picks the tick source; zero stops the counter
// - processor reads and writes the count with or without ticks
// - processor count write beats clear, increment or decrement in that cycle
// - 16-bit counter steps by one, direction up or down, clear zeroes it
// - floor indication at zero, ceiling indication at current top
// - counter high-byte location reaches the shared holding byte instead
// - reading counter low byte loads counter high byte into holding byte
// - writing counter low byte loads holding byte into high byte together
// - each tick clears, increments or decrements the counter per mode
// - four-bit waveform mode, split across control a and b, picks sequence
// - overflow flag set where the mode says, may request an interrupt
// - capture triggers on chosen edge of pin or comparator output
// - capture copies the full count into the capture value register
// - capture flag set in the same cycle as the copy
// - enabled capture flag requests interrupt and clears when serviced
// - writing one to capture flag clears it, zero leaves it
// - capture low byte read first loads holding byte with capture high byte
// - capture value accepts writes only in modes where it sets the top
// - one 8-bit holding byte is shared by all 16-bit registers
// - compare value reads return both bytes directly
`ifndef TIMER16_REGS_VH
`define TIMER16_REGS_VH
`define OFS_CTRL_A     4'h0
`define OFS_CTRL_B     4'h1
`define OFS_CNT_LO     4'h4
`define OFS_CNT_HI     4'h5
`define OFS_CAP_LO     4'h6
`define OFS_CAP_HI     4'h7
`define OFS_CMPA_LO    4'h8
`define OFS_CMPA_HI    4'h9
`define OFS_CMPB_LO    4'ha
`define OFS_CMPB_HI    4'hb
`define OFS_FLAGS      4'hc
`define OFS_MASK       4'hd
`define BIT_OVF        0
`define BIT_CAPF       5
`define BIT_EDGE       6
`define CTRL_RESET     8'h00
`define TAP0_W         3
`define TAP1_W         6
`define TAP2_W         8
`define TOP_8BIT       16'h00ff
`define TOP_9BIT       16'h01ff
`define TOP_10BIT      16'h03ff
`define TOP_MAX        16'hffff
`endif

// File: dv/timer16_capture_properties.sv
// Purpose: port checks for timer16_capture
// Assumes: one clock, synchronous active-high reset
// Notes:   the count is hidden, so checks lean on bus and irq timing
module timer16_capture_properties (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       rd,
  input wire logic       wr,
  input wire logic [7:0] rdata_ff,
  input wire logic       capture_irq_ack,
  input wire logic       overflow_irq_ack,
  input wire logic       capture_irq_ff,
  input wire logic       overflow_irq_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_bus_idle;
    !rd;
  endsequence
  sequence s_cap_clear;
    $past(capture_irq_ack) || $past(wr) || $past(wr, 2);
  endsequence
  sequence s_ovf_clear;
    $past(overflow_irq_ack) || $past(wr) || $past(wr, 2);
  endsequence
  chk_reset_quiet: assert property (disable iff (1'b0)
    rst |=> rdata_ff == 8'h00 && !capture_irq_ff && !overflow_irq_ff)
    else $error("outputs not quiet after reset");
  chk_rdata_idle: assert property (s_bus_idle |=> rdata_ff == 8'h00)
    else $error("read data without a read");
  chk_cap_ack: assert property (capture_irq_ack |=> !capture_irq_ff)
    else $error("capture irq kept after service");
  chk_ovf_ack: assert property (overflow_irq_ack |=> !overflow_irq_ff)
    else $error("overflow irq kept after service");
  chk_cap_rise: assert property ($rose(capture_irq_ff) |-> !$past(capture_irq_ack))
    else $error("capture irq rose while serviced");
  chk_ovf_rise: assert property ($rose(overflow_irq_ff) |-> !$past(overflow_irq_ack))
    else $error("overflow irq rose while serviced");
  chk_cap_fall: assert property ($fell(capture_irq_ff) |-> s_cap_clear)
    else $error("capture irq dropped with no cause");
  chk_ovf_fall: assert property ($fell(overflow_irq_ff) |-> s_ovf_clear)
    else $error("overflow irq dropped with no cause");
endmodule // timer16_capture_properties

bind timer16_capture timer16_capture_properties timer16_capture_properties_inst (
  .clk(clk), .rst(rst), .rd(rd), .wr(wr), .rdata_ff(rdata_ff),
  .capture_irq_ack(capture_irq_ack), .overflow_irq_ack(overflow_irq_ack),
  .capture_irq_ff(capture_irq_ff), .overflow_irq_ff(overflow_irq_ff));

// File: dv/cpu_bus_model.sv
// Purpose: processor side of the byte bus, notes expected read data
// Assumes: one access per two cycles, strobes dropped at the next edge
// Notes:   released data lines show the inverse of the last byte
module cpu_bus_model (
  input  wire logic       clk,
  output logic      [3:0] addr,
  output logic            wr,
  output logic            rd,
  output logic      [7:0] wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] exp_q[$];
  initial begin
    addr = 4'h0;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 8'h00;
  end
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    wdata <= ~d;
  endtask
  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rd8(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    acc(1'b0, a, 8'h00);
  endtask
  // whole pairs only, so no other access can slip between the bytes
  task automatic wr16(input logic [3:0] a, input logic [15:0] d);
    wr8(a + 4'h1, d[15:8]);
    wr8(a, d[7:0]);
  endtask
  task automatic rd16(input logic [3:0] a, input logic [15:0] e);
    rd8(a, e[7:0]);
    rd8(a + 4'h1, e[15:8]);
  endtask
endmodule // cpu_bus_model

// File: dv/sixteen_bit_timer_capture_tb_top.sv
// Purpose: self-checking bench for timer16_capture
// Assumes: 40 MHz clock, reset held 20 cycles
// Notes:   ticks come from the external pin so counts are exact
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module sixteen_bit_timer_capture_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [3:0] addr;
  logic       wr;
  logic       rd;
  logic [7:0] wdata;
  logic [7:0] rdata_ff;
  logic       ext_clk_pin = 1'b0;
  logic       capture_pin = 1'b0;
  logic       comparator_output = 1'b0;
  logic       capture_src_sel = 1'b0;
  logic       capture_irq_ack = 1'b0;
  logic       overflow_irq_ack = 1'b0;
  logic       capture_irq_ff;
  logic       overflow_irq_ff;
  logic       top_hit_ff;
  logic       bottom_hit_ff;
  logic [7:0] exp_v;
  logic       rd_lat = 1'b0;
  int         n_mismatch = 0;
  int         tests_run = 0;
  int         seed = 12632;
  logic [15:0] v;
  initial forever #12.5 clk = ~clk;
  cpu_bus_model m (.clk(clk), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata));
  timer16_capture timer16_capture_inst (.clk(clk), .rst(rst), .addr(addr), .wr(wr),
    .rd(rd), .wdata(wdata), .rdata_ff(rdata_ff), .ext_clk_pin(ext_clk_pin),
    .capture_pin(capture_pin), .comparator_output(comparator_output),
    .capture_src_sel(capture_src_sel), .capture_irq_ack(capture_irq_ack),
    .overflow_irq_ack(overflow_irq_ack), .capture_irq_ff(capture_irq_ff),
    .overflow_irq_ff(overflow_irq_ff), .top_hit_ff(top_hit_ff),
    .bottom_hit_ff(bottom_hit_ff));
  // read data is settled by the falling edge after the sampling edge
  always @(posedge clk) rd_lat <= rd;
  always @(negedge clk) begin
    if (rd_lat && m.exp_q.size() > 0) begin
      exp_v = m.exp_q.pop_front();
      `CHK(rdata_ff, exp_v)
    end
  end
  task automatic end_sim;
    if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge clk);
    n_mismatch++;
    end_sim;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    m.rd16(4'h4, 16'h0000);
    m.rd16(4'h6, 16'h0000);
    m.rd8(4'hc, 8'h00);
    @(negedge clk);
    `CHK(bottom_hit_ff, 1'b1)
    v = 16'($random(seed));
    m.wr16(4'h4, v);
    m.rd16(4'h4, v);
    m.wr8(4'h5, 8'ha5);
    m.wr8(4'h4, 8'h01);
    m.wr8(4'h8, 8'h02);
    m.rd8(4'h9, 8'ha5);
    m.rd16(4'h4, 16'ha501);
    m.wr16(4'h6, 16'h5678);
    m.rd16(4'h6, 16'h0000);
    m.wr8(4'h1, 8'h40);
    m.wr8(4'hd, 8'h20);
    capture_pin <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK(capture_irq_ff, 1'b1)
    m.rd16(4'h6, 16'ha501);
    m.rd8(4'hc, 8'h20);
    m.wr8(4'hc, 8'h00);
    m.rd8(4'hc, 8'h20);
    m.wr8(4'hc, 8'h20);
    m.rd8(4'hc, 8'h00);
    capture_src_sel <= 1'b1;
    m.wr8(4'hc, 8'h20);
    m.wr16(4'h4, 16'h0042);
    comparator_output <= 1'b1;
    repeat (4) @(posedge clk);
    m.rd16(4'h6, 16'h0042);
    capture_irq_ack <= 1'b1;
    @(posedge clk);
    capture_irq_ack <= 1'b0;
    m.rd8(4'hc, 8'h00);
    m.wr8(4'h1, 8'h18);
    m.wr16(4'h6, 16'h5678);
    m.rd16(4'h6, 16'h5678);
    m.wr8(4'h1, 8'h07);
    m.wr16(4'h4, 16'hfffe);
    m.wr8(4'hd, 8'h01);
    repeat (3) begin
      @(posedge clk);
      ext_clk_pin <= 1'b1;
      repeat (3) @(posedge clk);
      ext_clk_pin <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (4) @(posedge clk);
    `CHK(overflow_irq_ff, 1'b1)
    m.rd16(4'h4, 16'h0001);
    m.rd8(4'hc, 8'h01);
    overflow_irq_ack <= 1'b1;
    @(posedge clk);
    overflow_irq_ack <= 1'b0;
    m.rd8(4'hc, 8'h00);
    m.wr16(4'h4, 16'hffff);
    @(negedge clk);
    `CHK(top_hit_ff, 1'b1)
    `CHK(bottom_hit_ff, 1'b0)
    repeat (4) @(posedge clk);
    end_sim;
  end
endmodule // sixteen_bit_timer_capture_tb_top
